// >>> rtl/dmtc_pkg.sv
// Constants shared by the drive monitor, timer and counter block.
// Assumes a 200 MHz core clock and 16-bit parameter registers.
package dmtc_pkg;
    // Clock and time bases
    localparam int CLK_HZ = 200_000_000;
    localparam int TIMER_TICK_MS = 100;
    localparam int TIMER_TICK_CYCLES = TIMER_TICK_MS * (CLK_HZ / 1000);
    localparam int FILTER_TICK_US = 1000;
    localparam int FILTER_TICK_CYCLES = FILTER_TICK_US * (CLK_HZ / 1000000);
    // Pulse generator modulus: clock cycles per second times 100 per hertz
    localparam logic [35:0] PULSE_MOD = 36'(64'd100 * 64'(CLK_HZ));

    // Register bus widths
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int REG_COUNT = 18;

    // Register indexes
    localparam logic [4:0] REG_MON_SEL = 5'h00;
    localparam logic [4:0] REG_MON_GAIN = 5'h01;
    localparam logic [4:0] REG_SKIP_BW = 5'h02;
    localparam logic [4:0] REG_SKIP_PT0 = 5'h03;
    localparam logic [4:0] REG_REACH_ONE = 5'h06;
    localparam logic [4:0] REG_REACH_TWO = 5'h07;
    localparam logic [4:0] REG_REACH_HYST = 5'h08;
    localparam logic [4:0] REG_TIMER_ONE = 5'h09;
    localparam logic [4:0] REG_TIMER_TWO = 5'h0A;
    localparam logic [4:0] REG_CNT_SET = 5'h0B;
    localparam logic [4:0] REG_CNT_MID = 5'h0C;
    localparam logic [4:0] REG_AN_SEL = 5'h0D;
    localparam logic [4:0] REG_AN_FILT = 5'h0E;
    localparam logic [4:0] REG_AN_HIGH = 5'h0F;
    localparam logic [4:0] REG_AN_LOW = 5'h10;
    localparam logic [4:0] REG_BIAS = 5'h11;
    localparam logic [4:0] REG_STAT_COUNT = 5'h12;
    localparam logic [4:0] REG_STAT_FLAGS = 5'h13;

    // Bias register fields
    localparam int BIAS_LOW_DIR = 0;
    localparam int BIAS_HIGH_DIR = 1;
    localparam int BIAS_NEG_REV = 2;

    // Reset values, indexed by register
    localparam logic [15:0] REG_RESET [0:REG_COUNT-1] = '{
        16'h0000, 16'h03E8, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0032, 16'h0001, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0014, 16'h1388, 16'h0000, 16'h0000};

    // Scales
    localparam int GAIN_FULL = 1000;
    localparam int DC_BUS_FULL_V = 1000;
    localparam int CODE_FULL = 1023;
    localparam int STACK_FREQ = 5000;
    localparam int MA4_CODE = 205;
    localparam int MA4_SPAN = 818;
    localparam int TIMER_TWO_SCALE = 10;
    localparam int MAX_FILTER = 50;
    localparam int MAX_ANALOG_SEL = 10;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
endpackage : dmtc_pkg

// >>> rtl/dmtc_top.sv
// Drive monitor output, skip bands, reach detectors, timers, event
// counter and analog frequency command. Single clock, register port
// from local logic; timer, counter and clear contacts are raw pins.
`timescale 1ns/1ps

// What this block does
// - Selections 4..7 emit 1, 2, 3, 6 pulses per hertz, 50% duty.
// - Selections 0..3 scale frequency, current, DC bus 1000 V, AC voltage.
// - Analog monitor scaled by gain 0.0..100.0 percent, default 100.0.
// - Skip bandwidth zero disables all three skip points.
// - Each enabled skip point excludes a band twice the bandwidth.
// - Reach outputs assert when frequency exceeds each reach setting.
// - Reach detection has hysteresis 0..10.00 Hz, default 0.50 Hz.
// - Multi-pump: first reach is high speed; low speed while second is not reached.
// - Timer one spans 0.1..10.0 s, timer two 1..100 s.
// - Closed start input accumulates time, output asserts when reached.
// - Opening the start input clears time and deasserts output.
// - Trigger events counted; output asserts at set value 0..65500.
// - After clearing, counting resumes from zero.
// - Intermediate threshold 0..65500, default 0, asserts while the count is at or above it.
// - Analog select codes 0..10, including aux, averages, max, min.
// - Stacked input: half sum of normalized inputs times 50 Hz.
// - Analog filter constant 0..50, default 20; larger is slower.
// - Analog range mapped linearly between low and high frequency.
// - Each range end has a direction bit: 0 forward, 1 reverse.
// - Negative bias reverses only when reverse enable is 1.
// - Counter stops at 65535 until cleared.
// - Set output on equality; intermediate output on greater or equal.
module dmtc_top #(
    parameter int TICK_CYCLES = dmtc_pkg::TIMER_TICK_CYCLES,
    parameter int FILTER_CYCLES = dmtc_pkg::FILTER_TICK_CYCLES,
    parameter int MAX_FREQ = 40000
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic [dmtc_pkg::ADDR_W-1:0] regAddr,
    input wire logic [dmtc_pkg::DATA_W-1:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [dmtc_pkg::DATA_W-1:0] regRdData,
    input wire logic [15:0] runFreq,
    input wire logic [9:0] outCurrentNorm,
    input wire logic [9:0] dcBusVolt,
    input wire logic [9:0] acVoltNorm,
    input wire logic [9:0] voltageAnalogInput,
    input wire logic [9:0] currentAnalogInput,
    input wire logic [9:0] secondVoltageInput,
    input wire logic [9:0] auxAnalogInputA,
    input wire logic [9:0] auxAnalogInputB,
    input wire logic multiPump,
    input wire logic timerOneStartPin,
    input wire logic timerTwoStartPin,
    input wire logic counterTriggerPin,
    input wire logic counterClearPin,
    output logic monitorOutputPin,
    output logic [9:0] monitorLevel,
    output logic reachOne,
    output logic reachTwo,
    output logic pumpHighSpeed,
    output logic pumpLowSpeed,
    output logic timerOneDone,
    output logic timerTwoDone,
    output logic countReach,
    output logic countMidReach,
    output logic [15:0] freqCommand,
    output logic reverseCommand
);
    import dmtc_pkg::*;

    // Counter widths below cap the tick spans and the full-scale value
    if (TICK_CYCLES < 1 || FILTER_CYCLES < 1 || MAX_FREQ < 1
            || TICK_CYCLES > 33554432 || FILTER_CYCLES > 262144
            || MAX_FREQ > 65535)
        $error("dmtc_top: tick counts or MAX_FREQ out of range");

    logic [15:0] cfg [0:REG_COUNT-1];
    logic [1:0] startS1, startS2;
    logic trigS1, trigS2, trigPrev, clrS1, clrS2;
    logic [15:0] count;
    logic [24:0] tickCnt;
    logic tick;
    logic [10:0] elapsed [0:1];
    logic [10:0] target [0:1];
    logic [1:0] timerDone;
    logic [35:0] pulseAcc;
    logic [19:0] pulseStep;
    logic [9:0] monRaw;
    logic [9:0] anNorm;
    logic [17:0] filtCnt;
    logic [5:0] filtDiv;
    logic [13:0] filt;
    logic [15:0] rawMag;
    logic rawRev;
    logic [15:0] skipMag;
    logic trigRise;

    // Register writes; status indexes are read-only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                cfg[i] <= REG_RESET[i];
            end
        end else if (clkEn && regWrite && regAddr < 5'(REG_COUNT)) begin
            cfg[regAddr] <= regWrData;
        end
    end

    // Read data one cycle after the strobe, zero for unmapped indexes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdData <= 16'h0000;
        end else if (clkEn) begin
            if (!regRead) begin
                regRdData <= 16'h0000;
            end else if (regAddr < 5'(REG_COUNT)) begin
                regRdData <= cfg[regAddr];
            end else if (regAddr == REG_STAT_COUNT) begin
                regRdData <= count;
            end else if (regAddr == REG_STAT_FLAGS) begin
                regRdData <= {8'h00, reverseCommand, pumpLowSpeed,
                    countMidReach, countReach, timerDone, reachTwo,
                    reachOne};
            end else begin
                regRdData <= 16'h0000;
            end
        end
    end

    // Pin synchronisers; only the second stage feeds logic
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            startS1 <= 2'h0;
            startS2 <= 2'h0;
            trigS1 <= 1'b0;
            trigS2 <= 1'b0;
            trigPrev <= 1'b0;
            clrS1 <= 1'b0;
            clrS2 <= 1'b0;
        end else if (clkEn) begin
            startS1 <= {timerTwoStartPin, timerOneStartPin};
            startS2 <= startS1;
            trigS1 <= counterTriggerPin;
            trigS2 <= trigS1;
            trigPrev <= trigS2;
            clrS1 <= counterClearPin;
            clrS2 <= clrS1;
        end
    end

    // Event counter; an edge in the clear cycle counts as the first event
    assign trigRise = trigS2 && !trigPrev;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= 16'h0000;
        end else if (clkEn) begin
            if (clrS2) begin
                count <= trigRise ? 16'h0001 : 16'h0000;
            end else if (trigRise && count != COUNT_MAX) begin
                count <= count + 16'h0001;
            end
        end
    end

    // Reach flags follow the count; equality versus threshold
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            countReach <= 1'b0;
            countMidReach <= 1'b0;
        end else if (clkEn) begin
            countReach <= count == cfg[REG_CNT_SET];
            countMidReach <= count >= cfg[REG_CNT_MID];
        end
    end

    // Shared 0.1 s tick; long count kept as a parameter for simulation
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tickCnt <= 25'h0000000;
            tick <= 1'b0;
        end else if (clkEn) begin
            tick <= tickCnt == 25'(TICK_CYCLES - 1);
            if (tickCnt == 25'(TICK_CYCLES - 1)) begin
                tickCnt <= 25'h0000000;
            end else begin
                tickCnt <= tickCnt + 25'h0000001;
            end
        end
    end

    // Timer targets in tenths: one in 0.1 s, two in whole seconds
    assign target[0] = cfg[REG_TIMER_ONE][10:0];
    assign target[1] = 11'(cfg[REG_TIMER_TWO][6:0] * TIMER_TWO_SCALE);

    // Gated timers; elapsed is not aligned to the contact edge, so
    // the first tenth may be short by up to one tick
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 2; i++) begin
                elapsed[i] <= 11'h000;
            end
            timerDone <= 2'h0;
        end else if (clkEn) begin
            for (int i = 0; i < 2; i++) begin
                if (!startS2[i]) begin
                    elapsed[i] <= 11'h000;
                    timerDone[i] <= 1'b0;
                end else if (elapsed[i] >= target[i]) begin
                    timerDone[i] <= 1'b1;
                end else if (tick) begin
                    elapsed[i] <= elapsed[i] + 11'h001;
                end
            end
        end
    end
    assign timerOneDone = timerDone[0];
    assign timerTwoDone = timerDone[1];

    // Frequency reach with hysteresis below each threshold
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reachOne <= 1'b0;
            reachTwo <= 1'b0;
            pumpHighSpeed <= 1'b0;
            pumpLowSpeed <= 1'b0;
        end else if (clkEn) begin
            if (runFreq > cfg[REG_REACH_ONE]) begin
                reachOne <= 1'b1;
            end else if (17'(runFreq) + 17'(cfg[REG_REACH_HYST])
                    < 17'(cfg[REG_REACH_ONE])) begin
                reachOne <= 1'b0;
            end
            if (runFreq > cfg[REG_REACH_TWO]) begin
                reachTwo <= 1'b1;
            end else if (17'(runFreq) + 17'(cfg[REG_REACH_HYST])
                    < 17'(cfg[REG_REACH_TWO])) begin
                reachTwo <= 1'b0;
            end
            // Pump staging reads reach one as high, reach two clear as low
            pumpHighSpeed <= multiPump && reachOne;
            pumpLowSpeed <= multiPump && !reachTwo;
        end
    end

    // Pulses per hertz, doubled because each wrap is a half period
    always_comb begin
        case (cfg[REG_MON_SEL][2:0])
            3'h4: pulseStep = 20'(runFreq) * 20'h00002;
            3'h5: pulseStep = 20'(runFreq) * 20'h00004;
            3'h6: pulseStep = 20'(runFreq) * 20'h00006;
            3'h7: pulseStep = 20'(runFreq) * 20'h0000C;
            default: pulseStep = 20'h00000;
        endcase
    end

    // Phase accumulator; step follows runFreq every cycle, no latency
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pulseAcc <= 36'h000000000;
            monitorOutputPin <= 1'b0;
        end else if (clkEn) begin
            if (pulseStep == 20'h00000) begin
                pulseAcc <= 36'h000000000;
                monitorOutputPin <= 1'b0;
            end else if (pulseAcc + 36'(pulseStep) >= PULSE_MOD) begin
                pulseAcc <= pulseAcc + 36'(pulseStep) - PULSE_MOD;
                monitorOutputPin <= !monitorOutputPin;
            end else begin
                pulseAcc <= pulseAcc + 36'(pulseStep);
            end
        end
    end

    // Analog monitor source scaled to full code
    always_comb begin
        case (cfg[REG_MON_SEL][2:0])
            3'h0: monRaw = 10'(32'(runFreq) * CODE_FULL / MAX_FREQ);
            3'h1: monRaw = outCurrentNorm;
            3'h2: monRaw = 10'(32'(dcBusVolt) * CODE_FULL / DC_BUS_FULL_V);
            3'h3: monRaw = acVoltNorm;
            default: monRaw = 10'h000;
        endcase
    end

    // Gain in tenths of a percent
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            monitorLevel <= 10'h000;
        end else if (clkEn) begin
            monitorLevel <= 10'(32'(monRaw) * 32'(cfg[REG_MON_GAIN][9:0])
                / GAIN_FULL);
        end
    end

    // Analog input selection, normalised to 0..1023
    always_comb begin
        logic [11:0] sum;
        sum = 12'h000;
        case (cfg[REG_AN_SEL][3:0])
            4'h0: anNorm = voltageAnalogInput;
            4'h1: anNorm = voltageAnalogInput[9] ? 10'h3FF
                : {voltageAnalogInput[8:0], 1'b0};
            4'h2: anNorm = currentAnalogInput;
            4'h3: anNorm = (currentAnalogInput <= 10'(MA4_CODE)) ? 10'h000
                : 10'((32'(currentAnalogInput) - MA4_CODE) * CODE_FULL
                / MA4_SPAN);
            4'h4: begin
                sum = 12'(voltageAnalogInput) + 12'(currentAnalogInput);
                anNorm = sum[10:1];
            end
            4'h5: anNorm = auxAnalogInputA;
            4'h6: begin
                sum = 12'(voltageAnalogInput) + 12'(auxAnalogInputA);
                anNorm = sum[10:1];
            end
            4'h7: begin
                sum = 12'(secondVoltageInput) * 12'h003
                    + 12'(auxAnalogInputA);
                anNorm = sum[11:2];
            end
            4'h8: begin
                sum = 12'(auxAnalogInputA) + 12'(auxAnalogInputB);
                anNorm = sum[10:1];
            end
            4'h9: anNorm = (auxAnalogInputA > auxAnalogInputB)
                ? auxAnalogInputA : auxAnalogInputB;
            4'hA: anNorm = (auxAnalogInputA < auxAnalogInputB)
                ? auxAnalogInputA : auxAnalogInputB;
            default: anNorm = voltageAnalogInput;
        endcase
    end

    // First-order filter updated every (constant + 1) filter ticks
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            filtCnt <= 18'h00000;
            filtDiv <= 6'h00;
            filt <= 14'h0000;
        end else if (clkEn) begin
            if (filtCnt == 18'(FILTER_CYCLES - 1)) begin
                filtCnt <= 18'h00000;
                if (filtDiv >= cfg[REG_AN_FILT][5:0]
                        || filtDiv >= 6'(MAX_FILTER)) begin
                    filtDiv <= 6'h00;
                    // 17 bits so three times a full step cannot overflow
                    filt <= 14'($signed({3'b000, anNorm, 4'h0})
                        - ((($signed({3'b000, anNorm, 4'h0})
                        - $signed({3'b000, filt}))
                        * 17'sd3) >>> 2));
                end else begin
                    filtDiv <= filtDiv + 6'h01;
                end
            end else begin
                filtCnt <= filtCnt + 18'h00001;
            end
        end
    end

    // Linear map between signed range ends
    always_comb begin
        int sLow;
        int sHigh;
        int f;
        sLow = int'(cfg[REG_AN_LOW]);
        sHigh = int'(cfg[REG_AN_HIGH]);
        if (cfg[REG_BIAS][BIAS_LOW_DIR]) sLow = -sLow;
        if (cfg[REG_BIAS][BIAS_HIGH_DIR]) sHigh = -sHigh;
        f = sLow + (sHigh - sLow) * int'(filt[13:4]) / CODE_FULL;
        if (cfg[REG_AN_SEL][3:0] == 4'h4) begin
            f = int'(filt[13:4]) * STACK_FREQ / CODE_FULL;
        end
        rawRev = 1'b0;
        rawMag = 16'(f);
        if (f < 0) begin
            rawRev = cfg[REG_BIAS][BIAS_NEG_REV];
            rawMag = rawRev ? 16'(-f) : 16'h0000;
        end
    end

    // Skip bands snap to the lower band edge
    always_comb begin
        logic [16:0] pt;
        logic [16:0] bw;
        pt = 17'h00000;
        bw = 17'(cfg[REG_SKIP_BW]);
        skipMag = rawMag;
        for (int i = 0; i < 3; i++) begin
            pt = 17'(cfg[REG_SKIP_PT0 + 5'(i)]);
            if (bw != 17'h00000 && 17'(skipMag) + bw > pt
                    && 17'(skipMag) < pt + bw) begin
                skipMag = (pt > bw) ? 16'(pt - bw) : 16'h0000;
            end
        end
    end

    // Frequency command register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            freqCommand <= 16'h0000;
            reverseCommand <= 1'b0;
        end else if (clkEn) begin
            freqCommand <= skipMag;
            reverseCommand <= rawRev && skipMag != 16'h0000;
        end
    end

    sequence seqTrigRise;
        clkEn && trigS2 && !trigPrev && !clrS2;
    endsequence

    sequence seqCountFree;
        count != COUNT_MAX;
    endsequence

    AST_CNT_INC: assert property (@(posedge clk) disable iff (rst)
        seqTrigRise and seqCountFree |=> count == $past(count) + 16'h0001)
        else $error("count did not step on a trigger edge");
    AST_CNT_SAT: assert property (@(posedge clk) disable iff (rst)
        count == COUNT_MAX && !clrS2 |=> count == COUNT_MAX)
        else $error("count moved past its ceiling");
    AST_TIMER_CLR: assert property (@(posedge clk) disable iff (rst)
        clkEn && !startS2[0] |=> !timerOneDone && elapsed[0] == 11'h000)
        else $error("timer one not cleared on open contact");
    AST_TIMER_DONE: assert property (@(posedge clk) disable iff (rst)
        clkEn && startS2[1] && elapsed[1] >= target[1] |=> timerTwoDone)
        else $error("timer two missed its target");
    AST_REACH_SET: assert property (@(posedge clk) disable iff (rst)
        clkEn && runFreq > cfg[REG_REACH_ONE] |=> reachOne)
        else $error("reach one missed");
    AST_REACH_HOLD: assert property (@(posedge clk) disable iff (rst)
        clkEn && reachTwo && 17'(runFreq) + 17'(cfg[REG_REACH_HYST])
        >= 17'(cfg[REG_REACH_TWO]) |=> reachTwo)
        else $error("reach two dropped inside hysteresis");
    AST_SKIP_OFF: assert property (@(posedge clk) disable iff (rst)
        clkEn && cfg[REG_SKIP_BW] == 16'h0000 |=>
        freqCommand == $past(rawMag))
        else $error("skip applied with zero bandwidth");
    AST_SKIP_BAND: assert property (@(posedge clk) disable iff (rst)
        clkEn && cfg[REG_SKIP_BW] != 16'h0000 |=>
        !(17'(freqCommand) + 17'($past(cfg[REG_SKIP_BW]))
        > 17'($past(cfg[REG_SKIP_PT0 + 5'h02]))
        && 17'(freqCommand) < 17'($past(cfg[REG_SKIP_PT0 + 5'h02]))
        + 17'($past(cfg[REG_SKIP_BW]))))
        else $error("command inside last skip band");
    AST_NO_REV: assert property (@(posedge clk) disable iff (rst)
        clkEn && !cfg[REG_BIAS][BIAS_NEG_REV] |=> !reverseCommand)
        else $error("reverse without enable");
endmodule : dmtc_top

// >>> bench/dmtc_contacts.sv
// Model of the external contacts: counter trigger, counter clear and
// timer start switches. Assumes the bench calls its tasks in order.
`timescale 1ns/1ps
module dmtc_contacts #(
    parameter int HOLD = 400000
) (
    input wire logic clk,
    output logic trigPin,
    output logic clearPin,
    output logic startOne,
    output logic startTwo
);
    // Contacts open at power-up
    initial begin
        trigPin = 1'b0;
        clearPin = 1'b0;
        startOne = 1'b0;
        startTwo = 1'b0;
    end
    // Each closure held high then low for the minimum width
    task automatic trig(input int n);
        for (int i = 0; i < n; i++) begin
            trigPin <= 1'b1;
            repeat (HOLD) @(posedge clk);
            trigPin <= 1'b0;
            repeat (HOLD) @(posedge clk);
        end
    endtask : trig
    // Clear pulse, same minimum width as a trigger
    task automatic clr();
        clearPin <= 1'b1;
        repeat (HOLD) @(posedge clk);
        clearPin <= 1'b0;
        repeat (HOLD) @(posedge clk);
    endtask : clr
    // Bit 0 drives timer one start, bit 1 timer two start
    task automatic start(input logic [1:0] v);
        {startTwo, startOne} <= v;
    endtask : start
endmodule : dmtc_contacts

// >>> bench/dmtc_top_tb_top.sv
// Self-checking bench for dmtc_top: registers, counter, timers, reach,
// analog command path and monitor outputs.
// Assumes short tick parameters and a contacts model on the raw pins.
`timescale 1ns/1ps
module dmtc_top_tb_top;
    import dmtc_pkg::*;
    logic clk = 1'b0, rst = 1'b1, clkEn = 1'b1, regWrite = 1'b0;
    logic regRead = 1'b0, multiPump = 1'b0, tOne, tTwo, trg, clrPin;
    logic [4:0] regAddr = 5'h00;
    logic [15:0] regWrData = 16'h0000, runFreq = 16'h0000, rdv, cmd;
    logic [9:0] ana = 10'h200, vIn = 10'h200, iIn = 10'h200, lvl;
    logic mon, r1, r2, pH, pL, d1, d2, cR, cM, rev;
    int failures = 0, checked = 0;
    always #2.5 clk = ~clk;
    dmtc_contacts #(.HOLD(8)) contacts_u (.clk(clk), .trigPin(trg),
        .clearPin(clrPin), .startOne(tOne), .startTwo(tTwo));
    dmtc_top #(.TICK_CYCLES(10), .FILTER_CYCLES(4)) dut_u (.clk(clk),
        .rst(rst), .clkEn(clkEn), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(rdv), .runFreq(runFreq), .outCurrentNorm(ana),
        .dcBusVolt(ana), .acVoltNorm(ana), .voltageAnalogInput(vIn),
        .currentAnalogInput(iIn), .secondVoltageInput(ana),
        .auxAnalogInputA(vIn), .auxAnalogInputB(iIn),
        .multiPump(multiPump), .timerOneStartPin(tOne),
        .timerTwoStartPin(tTwo), .counterTriggerPin(trg),
        .counterClearPin(clrPin), .monitorOutputPin(mon),
        .monitorLevel(lvl), .reachOne(r1), .reachTwo(r2),
        .pumpHighSpeed(pH), .pumpLowSpeed(pL), .timerOneDone(d1),
        .timerTwoDone(d2), .countReach(cR), .countMidReach(cM),
        .freqCommand(cmd), .reverseCommand(rev));
    task automatic chk(input string n, input logic [15:0] e, g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1 d = rdv;
    endtask : rd
    // A write while clkEn is low must be lost
    task automatic test_regs();
        logic [15:0] v;
        clkEn <= 1'b0;
        wr(REG_MON_GAIN, 16'h0001);
        clkEn <= 1'b1;
        rd(REG_MON_GAIN, v);
        chk("gain", 16'h03E8, v);
        rd(REG_AN_HIGH, v);
        chk("high", 16'h1388, v);
        rd(REG_AN_FILT, v);
        chk("filt", 16'h0014, v);
        rd(5'h1F, v);
        chk("unmapped", 16'h0000, v);
        $display("test regs done");
    endtask : test_regs
    task automatic test_count();
        logic [15:0] v;
        wr(REG_CNT_SET, 16'h0003);
        wr(REG_CNT_MID, 16'h0002);
        contacts_u.clr();
        contacts_u.trig(2);
        chk("mid2", 16'h0001, cM);
        chk("set2", 16'h0000, cR);
        contacts_u.trig(1);
        chk("set3", 16'h0001, cR);
        contacts_u.trig(1);
        chk("set4", 16'h0000, cR);
        rd(REG_STAT_COUNT, v);
        chk("count", 16'h0004, v);
        contacts_u.clr();
        contacts_u.trig(1);
        rd(REG_STAT_COUNT, v);
        chk("recount", 16'h0001, v);
        $display("test count done");
    endtask : test_count
    // Timer one: two ticks of ten cycles; timer two: ten ticks
    task automatic test_timer();
        int n;
        wr(REG_TIMER_ONE, 16'h0002);
        wr(REG_TIMER_TWO, 16'h0001);
        contacts_u.start(2'b11);
        repeat (10) @(posedge clk);
        chk("early", 16'h0000, d1);
        n = 0;
        while (d1 !== 1'b1 && n < 60) begin
            @(posedge clk);
            n++;
        end
        chk("done", 16'h0001, d1);
        chk("early2", 16'h0000, d2);
        n = 0;
        while (d2 !== 1'b1 && n < 150) begin
            @(posedge clk);
            n++;
        end
        chk("done2", 16'h0001, d2);
        contacts_u.start(2'b00);
        repeat (5) @(posedge clk);
        chk("open", 16'h0000, d1);
        chk("open2", 16'h0000, d2);
        $display("test timer done");
    endtask : test_timer
    task automatic test_reach();
        wr(REG_REACH_ONE, 16'h03E8);
        multiPump <= 1'b1;
        runFreq <= 16'h03E9;
        repeat (4) @(posedge clk);
        chk("over", 16'h0001, r1);
        chk("pumpHi", 16'h0001, pH);
        chk("reachTwo", 16'h0001, r2);
        chk("pumpLo", 16'h0000, pL);
        runFreq <= 16'h03C0;
        repeat (4) @(posedge clk);
        chk("hyst", 16'h0001, r1);
        runFreq <= 16'h03AC;
        repeat (4) @(posedge clk);
        chk("under", 16'h0000, r1);
        wr(REG_REACH_TWO, 16'h1388);
        repeat (4) @(posedge clk);
        chk("pumpLo2", 16'h0001, pL);
        $display("test reach done");
    endtask : test_reach
    // Filter constant 0 so the command settles within 200 cycles
    task automatic test_analog();
        wr(REG_AN_FILT, 16'h0000);
        wr(REG_BIAS, 16'h0006);
        vIn <= 10'h3FF;
        repeat (200) @(posedge clk);
        chk("cmdRev", 16'h1388, cmd);
        chk("rev", 16'h0001, rev);
        wr(REG_SKIP_PT0 + 5'h02, 16'h1388);
        wr(REG_SKIP_BW, 16'h0064);
        repeat (4) @(posedge clk);
        chk("skip", 16'h1324, cmd);
        wr(REG_BIAS, 16'h0002);
        repeat (4) @(posedge clk);
        chk("negBlock", 16'h0000, cmd);
        chk("noRev", 16'h0000, rev);
        wr(REG_SKIP_BW, 16'h0000);
        wr(REG_BIAS, 16'h0000);
        repeat (4) @(posedge clk);
        chk("skipOff", 16'h1388, cmd);
        wr(REG_AN_SEL, 16'h0004);
        iIn <= 10'h000;
        repeat (200) @(posedge clk);
        chk("stack", 16'h09C1, cmd);
        $display("test analog done");
    endtask : test_analog
    // One toggle of the fastest pulse train takes about 25,432 cycles
    task automatic test_monitor();
        int n;
        runFreq <= 16'h4E20;
        repeat (3) @(posedge clk);
        chk("levelFull", 16'h01FF, lvl);
        wr(REG_MON_GAIN, 16'h01F4);
        repeat (3) @(posedge clk);
        chk("levelHalf", 16'h00FF, lvl);
        runFreq <= 16'hFFFF;
        wr(REG_MON_SEL, 16'h0007);
        repeat (25000) @(posedge clk);
        chk("pulseLow", 16'h0000, mon);
        n = 0;
        while (mon !== 1'b1 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        chk("pulseHigh", 16'h0001, mon);
        $display("test monitor done");
    endtask : test_monitor
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        test_regs();
        test_count();
        test_timer();
        test_reach();
        test_analog();
        test_monitor();
        end_sim();
    end
    // Run needs about 26,000 cycles; the limit allows 40,000
    initial begin
        #200000;
        failures++;
        end_sim();
    end
endmodule : dmtc_top_tb_top
